/* core/wdpm_top.sv */
// Operation
// - watchdog counts down on own rc clock
// - overflow while enabled resets device, except in stop
// - enable only from factory option
// - three low bits pick timeout, read/write
// - bit three flags a watchdog reset
// - any watchdog register access restarts watchdog
// - halt stops cpu, peripherals keep running
// - stop halts chip, watchdog/comparator live
// - halt wakes on enabled interrupt
// - stop wakes on port, comparator, watchdog
// - power-on/pin reset: 4096 or 16384
// - stop wake, watchdog, lvr: 128 or 4096
// - three-bit option picks clock source
// - range option picks frequency band
// - watchdog option: 0 enable, 1 disable
// - lvr enable and threshold range options
// - reset pin option: 0 enabled, 1 io
// - lvr holds reset while supply low
`timescale 1ns/1ps
`default_nettype none
module wdpm_top #(
  parameter int RC_TICKS_PER_MS = 32,
  parameter int WARM_LONG_RC    = wdpm_pkg::WARM_LONG_RC,
  parameter int WARM_LONG_XTAL  = wdpm_pkg::WARM_LONG_XTAL,
  parameter int WARM_SHORT_RC   = wdpm_pkg::WARM_SHORT_RC,
  parameter int WARM_SHORT_XTAL = wdpm_pkg::WARM_SHORT_XTAL
) (
  input  wire logic        clk,              // main oscillator clock
  input  wire logic        sys_rst,          // power-on reset
  input  wire logic        ce,               // clock enable
  input  wire logic [9:0]  s_axi_awaddr,     // write address
  input  wire logic        s_axi_awvalid,    // write address valid
  output logic             s_axi_awready,    // write address ready
  input  wire logic [31:0] s_axi_wdata,      // write data
  input  wire logic [3:0]  s_axi_wstrb,      // write strobes
  input  wire logic        s_axi_wvalid,     // write data valid
  output logic             s_axi_wready,     // write data ready
  output logic [1:0]       s_axi_bresp,      // write response
  output logic             s_axi_bvalid,     // write response valid
  input  wire logic        s_axi_bready,     // write response ready
  input  wire logic [9:0]  s_axi_araddr,     // read address
  input  wire logic        s_axi_arvalid,    // read address valid
  output logic             s_axi_arready,    // read address ready
  output logic [31:0]      s_axi_rdata,      // read data
  output logic [1:0]       s_axi_rresp,      // read response
  output logic             s_axi_rvalid,     // read valid
  input  wire logic        s_axi_rready,     // read ready
  input  wire logic        wdt_rc_clk,       // watchdog rc oscillator
  input  wire logic        reset_pin_n,      // external reset pin
  input  wire logic        lvr_supply_low,   // supply low
  input  wire logic        halt_exec,        // halt pulse
  input  wire logic        stop_exec,        // stop pulse
  input  wire logic        irq_any,          // interrupt
  input  wire logic        port_irq,         // port interrupt
  input  wire logic        comparator_output_interrupt, // comparator irq
  input  wire logic [2:0]  opt_oscillator_select, // factory clock source
  input  wire logic        opt_osc_range,    // factory frequency band
  input  wire logic        opt_wdt_disable,  // factory watchdog off
  input  wire logic        opt_lvr_enable,   // factory lvr on
  input  wire logic        opt_lvr_low,      // factory low threshold
  input  wire logic        opt_rst_pin_disable, // factory pin as io
  output logic             cpu_reset,        // cpu in reset
  output logic             cpu_run,          // cpu executing
  output logic             cpu_resume,       // wake-up release
  output logic             main_osc_en,      // main oscillator on
  output logic             periph_run,       // timers run
  output logic             wdt_active,       // watchdog enabled
  output logic [2:0]       oscillator_select, // clock source
  output logic             osc_range_low,    // low band
  output logic             lvr_threshold_low, // low lvr threshold
  output logic             lvr_active,       // lvr monitor enabled
  output logic             reset_pin_is_io,  // pin free for io
  output logic             wdt_reset_pulse   // overflow reset
);
  localparam int WD_CW = $clog2(wdpm_pkg::WD_MS_MAX * RC_TICKS_PER_MS + 1);
  if (RC_TICKS_PER_MS < 1) $error("wdpm_top: RC_TICKS_PER_MS must be at least 1");

  // straps captured in reset, frozen after
  logic [2:0] osc_sel_reg;
  logic       range_reg;
  logic       wd_off_reg;
  logic       lvr_en_reg;
  logic       lvr_lo_reg;
  logic       pin_off_reg;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      osc_sel_reg <= opt_oscillator_select;
      range_reg   <= opt_osc_range;
      wd_off_reg  <= opt_wdt_disable;
      lvr_en_reg  <= opt_lvr_enable;
      lvr_lo_reg  <= opt_lvr_low;
      pin_off_reg <= opt_rst_pin_disable;
    end
  end

  logic wd_en;
  logic xtal_mode;
  assign wd_en     = !wd_off_reg;
  assign xtal_mode = (osc_sel_reg == wdpm_pkg::OSC_CERAMIC) || (osc_sel_reg == wdpm_pkg::OSC_CRYSTAL)
                     || (osc_sel_reg == wdpm_pkg::OSC_LF_XTAL);

  // pins from outside the clock domain
  logic [2:0] pins_sync;
  wdpm_sync #(.W(3)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .async_i ({lvr_supply_low, reset_pin_n, wdt_rc_clk}),
    .init_i  (3'h2),
    .sync_o  (pins_sync)
  );
  logic rc_prev_reg;
  logic rc_tick;
  logic pin_rst_act;
  logic lvr_act;
  assign rc_tick     = pins_sync[0] && !rc_prev_reg;
  assign pin_rst_act = !pin_off_reg && !pins_sync[1];
  assign lvr_act     = lvr_en_reg && pins_sync[2];

  // axi4-lite slave state
  logic        aw_hold_reg, aw_hold_next;
  logic [9:0]  aw_addr_reg, aw_addr_next;
  logic        w_hold_reg, w_hold_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0]  w_strb_reg, w_strb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [2:0]  period_reg, period_next;
  logic        flag_reg, flag_next;
  logic        wr_do;
  logic        rd_do;
  logic        wd_access;
  logic        dev_rst_evt;
  logic        ovf_reset;
  wdpm_pkg::wdpm_state_t state_reg, state_next;

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign wr_do = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign rd_do = s_axi_arvalid && !rvalid_reg;
  assign wd_access = (wr_do && aw_addr_reg[9:2] == wdpm_pkg::REG_WD_IDX)
                     || (rd_do && s_axi_araddr[9:2] == wdpm_pkg::REG_WD_IDX);

  // aw and w in either order; b after both
  always_comb
  begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next  = w_hold_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    period_next  = period_reg;
    flag_next    = flag_reg || ovf_reset;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_do)
    begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wdpm_pkg::RESP_SLVERR;
      if (aw_addr_reg[9:2] == wdpm_pkg::REG_WD_IDX)
      begin
        bresp_next = wdpm_pkg::RESP_OKAY;
        if (w_strb_reg[0])
          period_next = w_data_reg[wdpm_pkg::PERIOD_LSB +: wdpm_pkg::PERIOD_W];
      end
      else if (aw_addr_reg[9:2] == wdpm_pkg::REG_STAT_IDX)
        bresp_next = wdpm_pkg::RESP_OKAY; // status read-only
    end
    else if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (rd_do)
    begin
      rvalid_next = 1'b1;
      rdata_next  = 32'h0000_0000;
      rresp_next  = wdpm_pkg::RESP_OKAY;
      case (s_axi_araddr[9:2])
        wdpm_pkg::REG_WD_IDX:
        begin
          rdata_next[wdpm_pkg::PERIOD_LSB +: wdpm_pkg::PERIOD_W] = period_reg;
          rdata_next[wdpm_pkg::FLAG_BIT] = flag_reg;
        end
        wdpm_pkg::REG_STAT_IDX:
        begin
          rdata_next[wdpm_pkg::STAT_OSC_LSB +: 3] = osc_sel_reg;
          rdata_next[wdpm_pkg::STAT_RANGE_BIT]    = range_reg;
          rdata_next[wdpm_pkg::STAT_WDOFF_BIT]    = wd_off_reg;
          rdata_next[wdpm_pkg::STAT_LVREN_BIT]    = lvr_en_reg;
          rdata_next[wdpm_pkg::STAT_LVRLO_BIT]    = lvr_lo_reg;
          rdata_next[wdpm_pkg::STAT_PINOFF_BIT]   = pin_off_reg;
          rdata_next[wdpm_pkg::STAT_STATE_LSB +: 5] = state_reg;
        end
        default: rresp_next = wdpm_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
    // device reset restores the period
    if (dev_rst_evt)
      period_next = wdpm_pkg::PERIOD_RESET;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 10'h000;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= wdpm_pkg::RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= wdpm_pkg::RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
      period_reg  <= wdpm_pkg::PERIOD_RESET;
      flag_reg    <= 1'b0;
    end
    else if (ce)
    begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg  <= w_hold_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      period_reg  <= period_next;
      flag_reg    <= flag_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

  // down-counter stepped by rc edges
  logic [WD_CW-1:0] wd_cnt_reg, wd_cnt_next;
  logic             held_in_reset;
  logic             wd_ovf;
  assign wd_ovf = wd_en && rc_tick && (wd_cnt_reg == '0) && !wd_access && !held_in_reset;
  always_comb
  begin
    wd_cnt_next = wd_cnt_reg;
    if (held_in_reset || wd_access || wd_ovf)
      wd_cnt_next = WD_CW'(wdpm_pkg::wd_timeout_ms(period_next) * RC_TICKS_PER_MS - 1);
    else if (wd_en && rc_tick)
      wd_cnt_next = wd_cnt_reg - WD_CW'(1);
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wd_cnt_reg  <= WD_CW'(wdpm_pkg::WD_MS_0 * RC_TICKS_PER_MS - 1);
      rc_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      wd_cnt_reg  <= wd_cnt_next;
      rc_prev_reg <= pins_sync[0];
    end
  end

  // power-mode and reset sequencer
  logic warm_start;
  logic warm_long;
  logic warm_done;
  logic resume_reg, resume_next;
  logic por_pend_reg, por_pend_next;
  logic long_reg, long_next;
  assign held_in_reset = (state_reg == wdpm_pkg::ST_LVR)
                         || (state_reg == wdpm_pkg::ST_WARM && !resume_reg);
  // overflow in stop is a wake-up, elsewhere a reset
  assign ovf_reset   = wd_ovf && (state_reg != wdpm_pkg::ST_STOP);
  assign dev_rst_evt = (state_next == wdpm_pkg::ST_LVR) || (warm_start && !resume_next);

  always_comb
  begin
    state_next    = state_reg;
    resume_next   = resume_reg;
    por_pend_next = 1'b0;
    long_next     = long_reg;
    warm_start    = 1'b0;
    if (por_pend_reg)
    begin
      warm_start = 1'b1;
      long_next  = 1'b1;
    end
    if (lvr_act)
    begin
      state_next  = wdpm_pkg::ST_LVR;
      resume_next = 1'b0;
    end
    else if (pin_rst_act)
    begin
      // restarts each cycle pin is low
      state_next  = wdpm_pkg::ST_WARM;
      resume_next = 1'b0;
      warm_start  = 1'b1;
      long_next   = 1'b1;
    end
    else if (ovf_reset)
    begin
      state_next  = wdpm_pkg::ST_WARM;
      resume_next = 1'b0;
      warm_start  = 1'b1;
      long_next   = 1'b0;
    end
    else
    begin
      case (state_reg)
        wdpm_pkg::ST_WARM:
          if (warm_done)
            state_next = wdpm_pkg::ST_RUN;
        wdpm_pkg::ST_RUN:
          if (stop_exec)
            state_next = wdpm_pkg::ST_STOP;
          else if (halt_exec)
            state_next = wdpm_pkg::ST_HALT;
        wdpm_pkg::ST_HALT:
          if (irq_any)
            state_next = wdpm_pkg::ST_RUN;
        wdpm_pkg::ST_STOP:
          if (port_irq || comparator_output_interrupt || wd_ovf)
          begin
            state_next  = wdpm_pkg::ST_WARM;
            resume_next = 1'b1;
            warm_start  = 1'b1;
            long_next   = 1'b0;
          end
        wdpm_pkg::ST_LVR:
        begin
          state_next  = wdpm_pkg::ST_WARM;
          resume_next = 1'b0;
          warm_start  = 1'b1;
          long_next   = 1'b0;
        end
        default: state_next = wdpm_pkg::ST_WARM;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg    <= wdpm_pkg::ST_WARM;
      resume_reg   <= 1'b0;
      por_pend_reg <= 1'b1;
      long_reg     <= 1'b1;
    end
    else if (ce)
    begin
      state_reg    <= state_next;
      resume_reg   <= resume_next;
      por_pend_reg <= por_pend_next;
      long_reg     <= long_next;
    end
  end

  assign warm_long = long_next;
  wdpm_warmup #(
    .LONG_RC    (WARM_LONG_RC),
    .LONG_XTAL  (WARM_LONG_XTAL),
    .SHORT_RC   (WARM_SHORT_RC),
    .SHORT_XTAL (WARM_SHORT_XTAL)
  ) u_warm (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .start    (warm_start),
    .long_sel (warm_long),
    .xtal     (xtal_mode),
    .busy     (),
    .done     (warm_done)
  );

  // registered one-cycle pulses
  logic resume_pulse_reg;
  logic wdt_pulse_reg;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      resume_pulse_reg <= 1'b0;
      wdt_pulse_reg    <= 1'b0;
    end
    else if (ce)
    begin
      resume_pulse_reg <= warm_done && resume_reg && state_next == wdpm_pkg::ST_RUN;
      wdt_pulse_reg    <= ovf_reset;
    end
  end

  // mode outputs decoded from the state and resume registers; straps and pulses from their own registers
  assign cpu_reset         = held_in_reset;
  assign cpu_run           = (state_reg == wdpm_pkg::ST_RUN);
  assign cpu_resume        = resume_pulse_reg;
  assign main_osc_en       = (state_reg != wdpm_pkg::ST_STOP);
  assign periph_run        = (state_reg == wdpm_pkg::ST_RUN) || (state_reg == wdpm_pkg::ST_HALT);
  assign wdt_active        = wd_en;
  assign oscillator_select = osc_sel_reg;
  assign osc_range_low     = range_reg;
  assign lvr_threshold_low = lvr_lo_reg;
  assign lvr_active        = lvr_en_reg;
  assign reset_pin_is_io   = pin_off_reg;
  assign wdt_reset_pulse   = wdt_pulse_reg;
endmodule
`default_nettype wire

/* core/wdpm_pkg.sv */
package wdpm_pkg;
  // register indices; byte address is index times four
  localparam logic [7:0] REG_WD_IDX   = 8'h1E;
  localparam logic [7:0] REG_STAT_IDX = 8'h1F;
  localparam logic [9:0] REG_WD_ADDR   = {REG_WD_IDX, 2'h0};
  localparam logic [9:0] REG_STAT_ADDR = {REG_STAT_IDX, 2'h0};
  // watchdog register fields
  localparam int PERIOD_LSB = 0;
  localparam int PERIOD_W   = 3;
  localparam int FLAG_BIT   = 3;
  localparam logic [2:0] PERIOD_RESET = 3'h0;
  // status register fields
  localparam int STAT_OSC_LSB   = 0;
  localparam int STAT_RANGE_BIT = 3;
  localparam int STAT_WDOFF_BIT = 4;
  localparam int STAT_LVREN_BIT = 5;
  localparam int STAT_LVRLO_BIT = 6;
  localparam int STAT_PINOFF_BIT = 7;
  localparam int STAT_STATE_LSB = 8;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // oscillator_select codes
  localparam logic [2:0] OSC_EXT_CLK = 3'h0;
  localparam logic [2:0] OSC_IRC_2M  = 3'h1;
  localparam logic [2:0] OSC_IRC_4M  = 3'h2;
  localparam logic [2:0] OSC_IRC_6M  = 3'h3;
  localparam logic [2:0] OSC_EXT_RC  = 3'h4;
  localparam logic [2:0] OSC_CERAMIC = 3'h5;
  localparam logic [2:0] OSC_CRYSTAL = 3'h6;
  localparam logic [2:0] OSC_LF_XTAL = 3'h7;
  // warm-up divide ratios in oscillator cycles
  localparam int WARM_LONG_RC    = 4096;
  localparam int WARM_LONG_XTAL  = 16384;
  localparam int WARM_SHORT_RC   = 128;
  localparam int WARM_SHORT_XTAL = 4096;
  // watchdog timeouts in ms
  localparam int WD_MS_0 = 4096;
  localparam int WD_MS_1 = 1024;
  localparam int WD_MS_2 = 256;
  localparam int WD_MS_3 = 128;
  localparam int WD_MS_4 = 64;
  localparam int WD_MS_5 = 16;
  localparam int WD_MS_6 = 4;
  localparam int WD_MS_7 = 1;
  localparam int WD_MS_MAX = WD_MS_0;
  // main clock rate
  localparam int CLK_HZ = 100000000;

  typedef enum logic [4:0] {
    ST_WARM = 5'h01,
    ST_RUN  = 5'h02,
    ST_HALT = 5'h04,
    ST_STOP = 5'h08,
    ST_LVR  = 5'h10
  } wdpm_state_t;

  function automatic int wd_timeout_ms(input logic [2:0] sel);
    case (sel)
      3'h0:    wd_timeout_ms = WD_MS_0;
      3'h1:    wd_timeout_ms = WD_MS_1;
      3'h2:    wd_timeout_ms = WD_MS_2;
      3'h3:    wd_timeout_ms = WD_MS_3;
      3'h4:    wd_timeout_ms = WD_MS_4;
      3'h5:    wd_timeout_ms = WD_MS_5;
      3'h6:    wd_timeout_ms = WD_MS_6;
      default: wd_timeout_ms = WD_MS_7;
    endcase
  endfunction
endpackage

/* core/wdpm_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module wdpm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,     // main clock
  input  wire logic         sys_rst, // sync reset
  input  wire logic         ce,      // clock enable
  input  wire logic [W-1:0] async_i, // outside-domain inputs
  input  wire logic [W-1:0] init_i,  // value shown after reset
  output logic      [W-1:0] sync_o   // agreed level
);
  if (W < 1) $error("wdpm_sync: W must be at least 1");

  // 3 stages; change taken once stages 2 and 3 agree
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;
    logic out_next;
    always_comb
    begin
      out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
    end
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        s1_reg  <= init_i[i];
        s2_reg  <= init_i[i];
        s3_reg  <= init_i[i];
        out_reg <= init_i[i];
      end
      else if (ce)
      begin
        s1_reg  <= async_i[i];
        s2_reg  <= s1_reg;
        s3_reg  <= s2_reg;
        out_reg <= out_next;
      end
    end
    assign sync_o[i] = out_reg;
  end
endmodule
`default_nettype wire

/* core/wdpm_warmup.sv */
`timescale 1ns/1ps
`default_nettype none
module wdpm_warmup #(
  parameter int LONG_RC    = wdpm_pkg::WARM_LONG_RC,
  parameter int LONG_XTAL  = wdpm_pkg::WARM_LONG_XTAL,
  parameter int SHORT_RC   = wdpm_pkg::WARM_SHORT_RC,
  parameter int SHORT_XTAL = wdpm_pkg::WARM_SHORT_XTAL
) (
  input  wire logic clk,      // oscillator clock
  input  wire logic sys_rst,  // sync reset
  input  wire logic ce,       // clock enable
  input  wire logic start,    // restart the warm-up
  input  wire logic long_sel, // power-on or pin reset ratio
  input  wire logic xtal,     // crystal or ceramic mode
  output logic      busy,     // counting
  output logic      done      // last cycle of warm-up
);
  localparam int CW = $clog2(LONG_XTAL + 1);
  if (LONG_RC < 1 || LONG_XTAL < 1 || SHORT_RC < 1 || SHORT_XTAL < 1)
    $error("wdpm_warmup: divide ratios must be at least 1");

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          busy_reg;
  logic          busy_next;
  logic [CW-1:0] load_val;

  // ratio by warm-up cause and oscillator
  always_comb
  begin
    case ({long_sel, xtal})
      2'h3:    load_val = CW'(LONG_XTAL - 1);
      2'h2:    load_val = CW'(LONG_RC - 1);
      2'h1:    load_val = CW'(SHORT_XTAL - 1);
      default: load_val = CW'(SHORT_RC - 1);
    endcase
  end

  // restart wins over an ongoing count
  always_comb
  begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    if (start)
    begin
      cnt_next  = load_val;
      busy_next = 1'b1;
    end
    else if (busy_reg)
    begin
      if (cnt_reg == '0)
        busy_next = 1'b0;
      else
        cnt_next = cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end
    else if (ce)
    begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign busy = busy_reg;
  assign done = busy_reg && (cnt_reg == '0) && !start;
endmodule
`default_nettype wire

/* verification/wdpm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module wdpm_monitor (
  input wire logic clk,             // clock
  input wire logic sys_rst,         // reset
  input wire logic halt_exec,       // halt
  input wire logic stop_exec,       // stop
  input wire logic irq_any,         // irq
  input wire logic lvr_supply_low,  // supply low
  input wire logic reset_pin_n,     // pin
  input wire logic cpu_reset,       // cpu reset
  input wire logic cpu_run,         // cpu run
  input wire logic cpu_resume,      // resume
  input wire logic main_osc_en,     // osc on
  input wire logic periph_run,      // timers
  input wire logic wdt_active,      // wd on
  input wire logic lvr_active,      // lvr on
  input wire logic reset_pin_is_io, // pin io
  input wire logic wdt_reset_pulse  // wd reset
);
  // one domain, quiet in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_wd_fixed: assert property (!$past(sys_rst) |-> $stable(wdt_active))
    else $error("watchdog enable moved");
  chk_straps_fixed: assert property (!$past(sys_rst) |-> $stable({lvr_active, reset_pin_is_io}))
    else $error("strap copy moved");
  chk_halt_entry: assert property (cpu_run && halt_exec && !stop_exec |=> periph_run && !cpu_run)
    else $error("halt not entered");
  chk_stop_entry: assert property (cpu_run && stop_exec |=> !main_osc_en && !periph_run)
    else $error("stop not entered");
  chk_halt_wake: assert property (periph_run && !cpu_run && irq_any |=> cpu_run)
    else $error("halt did not wake");
  chk_ovf_reset: assert property (wdt_reset_pulse |-> cpu_reset && !cpu_run)
    else $error("overflow without reset");
  // sync latency: hold judged late
  chk_lvr_hold: assert property ((lvr_active && lvr_supply_low) [*8] |-> cpu_reset)
    else $error("low supply not held");
  chk_pin_hold: assert property ((!reset_pin_is_io && !reset_pin_n) [*8] |-> cpu_reset)
    else $error("pin reset not held");
  chk_warm_hold: assert property ($rose(cpu_reset) |=> !cpu_run [*2])
    else $error("cpu ran during warm-up");
  cover property (cpu_resume);
  cover property (wdt_reset_pulse);
  cover property (periph_run && !cpu_run);
endmodule
bind wdpm_top wdpm_monitor mon (.*);
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic [9:0]  s_axi_awaddr, s_axi_araddr, wa, sa;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  opt_oscillator_select, oscillator_select, ev;
  logic [7:0]  opt, st;
  logic        clk, sys_rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        wdt_rc_clk, reset_pin_n, lvr_supply_low, halt_exec, stop_exec, irq_any, port_irq;
  logic        comparator_output_interrupt, opt_osc_range, opt_wdt_disable, opt_lvr_enable, opt_lvr_low;
  logic        opt_rst_pin_disable, cpu_reset, cpu_run, cpu_resume, main_osc_en, periph_run, wdt_active;
  logic        osc_range_low, lvr_threshold_low, lvr_active, reset_pin_is_io, wdt_reset_pulse;
  int          n_errors = 0;
  int          cmp_count = 0;
  // write upper nibble, expect lower
  logic [7:0]  rows [8] = '{8'h80, 8'h11, 8'hA2, 8'h33, 8'hC4, 8'h55, 8'hE6, 8'h77};
  // short counts keep the run small
  wdpm_top #(.RC_TICKS_PER_MS(1), .WARM_LONG_RC(8), .WARM_LONG_XTAL(16), .WARM_SHORT_RC(4),
    .WARM_SHORT_XTAL(8)) uut (.*);
  assign {opt_rst_pin_disable, opt_lvr_low, opt_lvr_enable, opt_wdt_disable, opt_osc_range,
    opt_oscillator_select} = opt;
  assign ev = {cpu_resume, wdt_reset_pulse, cpu_run};
  assign st = {oscillator_select, osc_range_low, wdt_active, lvr_active, lvr_threshold_low, reset_pin_is_io};
  assign wa = wdpm_pkg::REG_WD_ADDR;
  assign sa = wdpm_pkg::REG_STAT_ADDR;
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // valid held until ready; bready, rready stay high
  task wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    chk("bresp", wdpm_pkg::RESP_OKAY, s_axi_bresp);
  endtask
  task rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task rc(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("rdata", e, d);
  endtask
  // bounded wait on ev[k]
  task wt(input int k);
    int t;
    t = 0;
    while (ev[k] !== 1'b1 && t < 300)
    begin
      @(posedge clk);
      t++;
    end
    chk("event", 1'b1, ev[k]);
  endtask
  task tick(input int n);
    repeat (n)
    begin
      wdt_rc_clk <= 1'b1;
      repeat (3) @(posedge clk);
      wdt_rc_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  initial
  begin
    #100us;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, wdt_rc_clk, lvr_supply_low, halt_exec} <= '0;
    {stop_exec, irq_any, port_irq, comparator_output_interrupt, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    {s_axi_bready, s_axi_rready, reset_pin_n, ce, sys_rst} <= '1;
    s_axi_wstrb <= 4'hF;
    opt <= 8'h6D;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    wt(0);
    rc(wa, 32'h0);
    rc(sa, {19'h0, wdpm_pkg::ST_RUN, 8'h6D});
    chk("straps", 8'hBE, st);
    for (int i = 0; i < 8; i++)
    begin
      wr(wa, {28'h0, rows[i][7:4]}, r);
      rc(wa, {28'h0, rows[i][3:0]});
    end
    wr(sa, 32'h0, r);
    chk("bresp", wdpm_pkg::RESP_OKAY, r);
    rd(10'h000, d, r);
    chk("rresp", wdpm_pkg::RESP_SLVERR, r);
    // 4 ticks: a read after 3 defers overflow
    wr(wa, 32'h6, r);
    tick(3);
    rc(wa, 32'h6);
    tick(3);
    chk("run", 1'b1, cpu_run);
    wdt_rc_clk <= 1'b1;
    wt(1);
    wdt_rc_clk <= 1'b0;
    chk("reset", 1'b1, cpu_reset);
    wt(0);
    rc(wa, 32'h8);
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    @(posedge clk);
    chk("halt", 2'h1, {cpu_run, periph_run});
    irq_any <= 1'b1;
    repeat (2) @(posedge clk);
    irq_any <= 1'b0;
    chk("wake", 1'b1, cpu_run);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    @(posedge clk);
    chk("stop", 3'h0, {cpu_run, periph_run, main_osc_en});
    port_irq <= 1'b1;
    @(posedge clk);
    port_irq <= 1'b0;
    wt(2);
    chk("resume", 1'b0, cpu_reset);
    lvr_supply_low <= 1'b1;
    repeat (10) @(posedge clk);
    chk("lvr", 1'b1, cpu_reset);
    lvr_supply_low <= 1'b0;
    wt(0);
    reset_pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("pin", 1'b1, cpu_reset);
    reset_pin_n <= 1'b1;
    wt(0);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    comparator_output_interrupt <= 1'b1;
    @(posedge clk);
    comparator_output_interrupt <= 1'b0;
    wt(2);
    opt <= 8'h90;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    wt(0);
    rc(wa, 32'h0);
    chk("straps", 8'h01, st);
    // watchdog off, pin as io: cpu keeps running
    reset_pin_n <= 1'b0;
    wr(wa, 32'h7, r);
    tick(3);
    chk("run", 1'b1, cpu_run);
    tally_and_finish();
  end
endmodule
`default_nettype wire
